// ===== shared/gain_align_pkg.sv
// Constants, register map and carrier types for the protection-gain block
// Functional notes
// - Battery limiter acts only below 3.2 V
// - Battery limit gain is 21 dB plus offset
// - Limiter idle when programmed gain below limit
// - Offset table from 3.2 V down to 2.7 V
// - Output gain is minimum of three limiters
// - Send limiter/brownout word in 24-bit slot
// - Slot holds 11+13 bits, or 12 bits
// - Transmit in chosen slot only when enabled
// - Listen only on slots flagged in mask
// - Each alignment kind has its own enable
// - Link slots timed from bit clock, frame sync
// - Link disabled means traffic goes on TDM output
// - Link pin function field and own keeper
// - Converter results readable; battery result feeds battery limiter
// - Battery converted by default, enable can stop it
// - Converter samples at 192 kHz, 5.2 us each
// - Die temperature sampled 10k per second
// - Powered-down sense channel returns null samples
// - DC block filter with cutoff or bypass
package gain_align_pkg;
  localparam int unsigned SYS_CLK_HZ     = 10_000_000;
  localparam int unsigned CONV_RATE_HZ   = 192_000;
  localparam int unsigned CONV_TIME_NS   = 5200;
  localparam int unsigned TEMP_RATE_HZ   = 10_000;
  localparam int unsigned CONV_PERIOD    = SYS_CLK_HZ / CONV_RATE_HZ;
  localparam int unsigned CONV_CYCLES    = (CONV_TIME_NS * (SYS_CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned TEMP_PERIOD    = SYS_CLK_HZ / TEMP_RATE_HZ;
  localparam int unsigned SLOT_BITS      = 24;
  localparam int unsigned GROUP_MAX      = 8;
  // Gains in hundredths of a dB, battery readings in millivolts
  localparam logic signed [15:0] BASE_LIMIT_GAIN = 16'sh0834;
  localparam logic signed [15:0] GAIN_UNLIMITED  = 16'sh7fff;
  localparam logic [11:0] BAT_MV_3V2 = 12'hc80;
  localparam logic [11:0] BAT_MV_3V1 = 12'hc1c;
  localparam logic [11:0] BAT_MV_3V0 = 12'hbb8;
  localparam logic [11:0] BAT_MV_2V9 = 12'hb54;
  localparam logic [11:0] BAT_MV_2V8 = 12'haf0;
  localparam logic signed [15:0] OFS_3V2 = 16'sh0000;
  localparam logic signed [15:0] OFS_3V1 = -16'sh0032;
  localparam logic signed [15:0] OFS_3V0 = -16'sh004b;
  localparam logic signed [15:0] OFS_2V9 = -16'sh0078;
  localparam logic signed [15:0] OFS_2V8 = -16'sh009c;
  localparam logic signed [15:0] OFS_2V7 = -16'sh00c8;
  localparam logic [2:0] LINK_FN_ALIGN = 3'h1;
  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_SLOTS  = 8'h04;
  localparam logic [7:0] ADDR_GAINS  = 8'h08;
  localparam logic [7:0] ADDR_RESV   = 8'h0c;
  localparam logic [7:0] ADDR_RES_T  = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;
  localparam logic [7:0] ADDR_ALIGN  = 8'h18;
  localparam logic [7:0] CTRL_RESET  = 8'h08;
  typedef enum logic [1:0] {CH_SUPPLY, CH_BATTERY, CH_TEMP} adc_chan_t;
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } apb_req_t;
  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } apb_rsp_t;
endpackage : gain_align_pkg

// ===== src/gain_limit_alignment.sv
// Battery limiter, gain minimum, slot alignment, monitor sequencing and sense filtering
//
// Decided for this implementation: the APB register port and the register addresses.
`timescale 1ns/10ps
module gain_limit_alignment
  import gain_align_pkg::*;
(
  // Clock and reset
  input  wire logic                          sys_clk,
  input  wire logic                          reset,
  // Register bus
  input  wire gain_align_pkg::apb_req_t      apbReq,
  output gain_align_pkg::apb_rsp_t           apbRsp,
  // Serial audio clocks and data pins
  input  wire logic                          bitClk,
  input  wire logic                          frameSync,
  input  wire logic                          tdmDataIn,
  output logic                               tdmDataOut,
  output logic                               tdmDataOe,
  input  wire logic                          chipLinkIn,
  output logic                               chipLinkOut,
  output logic                               chipLinkOe,
  output logic                               chipLinkKeeper,
  // Limiter interface
  input  wire logic signed [15:0]            supplyLimiterGain,
  input  wire logic signed [15:0]            brownoutGain,
  input  wire logic [11:0]                   limiterReduction,
  input  wire logic [12:0]                   brownoutReduction,
  output logic signed [15:0]                 finalGain,
  output logic [11:0]                        alignedLimiterReduction,
  output logic [12:0]                        alignedBrownoutReduction,
  // Monitor converter
  output logic                               adcStart,
  output gain_align_pkg::adc_chan_t          adcChannel,
  input  wire logic [11:0]                   adcResult,
  // Sense converters
  input  wire logic signed [15:0]            currentSample,
  input  wire logic signed [15:0]            voltageSample,
  input  wire logic                          senseValid,
  output logic signed [15:0]                 currentOut,
  output logic signed [15:0]                 voltageOut
);
  import gain_align_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Register bus: one wait state, writes land when pready is seen high
  logic [7:0]  ctrl_reg;
  logic [31:0] slots_reg;
  logic [31:0] gains_reg;
  logic [11:0] supplyRes_reg, batteryRes_reg;
  logic [7:0]  tempRes_reg;
  logic        batActive_reg;
  apb_rsp_t    rsp_reg;
  wire         access  = apbReq.psel & apbReq.penable;
  wire         doWrite = access & rsp_reg.pready & apbReq.pwrite;
  wire         mapped  = apbReq.paddr inside {ADDR_CTRL, ADDR_SLOTS, ADDR_GAINS, ADDR_RESV, ADDR_RES_T,
                                              ADDR_STATUS, ADDR_ALIGN};
  wire         txEnable     = ctrl_reg[0];
  wire         limAlignEn   = ctrl_reg[1];
  wire         bopAlignEn   = ctrl_reg[2];
  wire         batConvEn    = ctrl_reg[3];
  wire         isnsPd       = ctrl_reg[4];
  wire         vsnsPd       = ctrl_reg[5];
  wire         keeperEn     = ctrl_reg[7];
  wire [5:0]   txSlot       = slots_reg[5:0];
  wire [5:0]   firstSlot    = slots_reg[13:8];
  wire [7:0]   listenMask   = slots_reg[23:16];
  wire [2:0]   linkFn       = slots_reg[26:24];
  wire [2:0]   dcCutoff     = slots_reg[30:28];
  wire signed [15:0] ampLevel = gains_reg[15:0];
  wire signed [15:0] volume   = gains_reg[31:16];
  logic [31:0] readWord;
  always_comb
  begin
    unique case (apbReq.paddr)
      ADDR_CTRL:   readWord = {24'h000000, ctrl_reg};
      ADDR_SLOTS:  readWord = slots_reg;
      ADDR_GAINS:  readWord = gains_reg;
      ADDR_RESV:   readWord = {4'h0, supplyRes_reg, 4'h0, batteryRes_reg};
      ADDR_RES_T:  readWord = {24'h000000, tempRes_reg};
      ADDR_STATUS: readWord = {15'h0000, batActive_reg, finalGain};
      ADDR_ALIGN:  readWord = {3'h0, alignedBrownoutReduction, 4'h0, alignedLimiterReduction};
      default:     readWord = 32'h00000000;
    endcase
  end
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      rsp_reg   <= '0;
      ctrl_reg  <= CTRL_RESET;
      slots_reg <= 32'h00000000;
      gains_reg <= 32'h00000000;
    end
    else
    begin
      rsp_reg.pready  <= access & ~rsp_reg.pready;
      rsp_reg.prdata  <= (access & ~rsp_reg.pready & ~apbReq.pwrite) ? readWord : rsp_reg.prdata;
      rsp_reg.pslverr <= access & ~rsp_reg.pready & ~mapped;
      if (doWrite && apbReq.paddr == ADDR_CTRL)
        ctrl_reg <= apbReq.pwdata[7:0];
      if (doWrite && apbReq.paddr == ADDR_SLOTS)
        slots_reg <= apbReq.pwdata;
      if (doWrite && apbReq.paddr == ADDR_GAINS)
        gains_reg <= apbReq.pwdata;
    end
  end
  assign apbRsp = rsp_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Monitor converter sequencing
  logic [7:0]  rateCnt_reg;
  logic [9:0]  tempCnt_reg;
  logic [7:0]  convCnt_reg;
  logic        tempDue_reg, battNext_reg, busy_reg, start_reg;
  adc_chan_t   chan_reg;
  wire         rateTick = (rateCnt_reg == 8'(CONV_PERIOD - 1));
  wire         tempTick = (tempCnt_reg == 10'(TEMP_PERIOD - 1));
  wire         convDone = busy_reg & (convCnt_reg == 8'(CONV_CYCLES - 1));
  wire adc_chan_t nextChan = tempDue_reg ? CH_TEMP
                            : (battNext_reg & batConvEn) ? CH_BATTERY : CH_SUPPLY;
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      rateCnt_reg   <= 8'h00;
      tempCnt_reg   <= 10'h000;
      convCnt_reg   <= 8'h00;
      tempDue_reg   <= 1'b0;
      battNext_reg  <= 1'b0;
      busy_reg      <= 1'b0;
      start_reg     <= 1'b0;
      chan_reg      <= CH_SUPPLY;
      supplyRes_reg <= 12'h000;
      batteryRes_reg <= 12'h000;
      tempRes_reg   <= 8'h00;
    end
    else
    begin
      rateCnt_reg <= rateTick ? 8'h00 : rateCnt_reg + 8'h01;
      tempCnt_reg <= tempTick ? 10'h000 : tempCnt_reg + 10'h001;
      start_reg   <= rateTick;
      if (tempTick)
        tempDue_reg <= 1'b1;
      else if (rateTick && tempDue_reg)
        tempDue_reg <= 1'b0;
      if (rateTick)
      begin
        chan_reg     <= nextChan;
        busy_reg     <= 1'b1;
        convCnt_reg  <= 8'h00;
        if (nextChan != CH_TEMP)
          battNext_reg <= ~battNext_reg;
      end
      else if (convDone)
        busy_reg <= 1'b0;
      else if (busy_reg)
        convCnt_reg <= convCnt_reg + 8'h01;
      if (convDone)
      begin
        unique case (chan_reg)
          CH_SUPPLY:  supplyRes_reg  <= adcResult;
          CH_BATTERY: batteryRes_reg <= adcResult;
          CH_TEMP:    tempRes_reg    <= adcResult[11:4];
          default:    tempRes_reg    <= tempRes_reg;
        endcase
      end
    end
  end
  assign adcStart   = start_reg;
  assign adcChannel = chan_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Battery tracking limiter and final gain
  function automatic logic signed [15:0] batteryOffset(input logic [11:0] mv);
    if (mv >= BAT_MV_3V2)      batteryOffset = OFS_3V2;
    else if (mv >= BAT_MV_3V1) batteryOffset = OFS_3V1;
    else if (mv >= BAT_MV_3V0) batteryOffset = OFS_3V0;
    else if (mv >= BAT_MV_2V9) batteryOffset = OFS_2V9;
    else if (mv >= BAT_MV_2V8) batteryOffset = OFS_2V8;
    else                       batteryOffset = OFS_2V7;
  endfunction : batteryOffset
  function automatic logic signed [15:0] minGain(input logic signed [15:0] a, input logic signed [15:0] b);
    minGain = (a < b) ? a : b;
  endfunction : minGain
  wire signed [15:0] batLimitGain = BASE_LIMIT_GAIN + batteryOffset(batteryRes_reg);
  wire signed [16:0] progGain     = 17'(ampLevel) + 17'(volume);
  wire               batActive    = (batteryRes_reg < BAT_MV_3V2)
                                    && !(progGain < 17'(batLimitGain));
  wire signed [15:0] batGain      = batActive ? batLimitGain : GAIN_UNLIMITED;
  wire signed [15:0] gainNext     = minGain(minGain(supplyLimiterGain, brownoutGain), batGain);
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      finalGain     <= GAIN_UNLIMITED;
      batActive_reg <= 1'b0;
    end
    else
    begin
      finalGain     <= gainNext;
      batActive_reg <= batActive;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Slot timing from synchronised bit clock and frame sync
  logic [3:0] sync1_reg, sync2_reg;
  logic       bclkPrev_reg, fsPrev_reg;
  logic [4:0] bitPos_reg;
  logic [5:0] slotPos_reg;
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      sync1_reg <= 4'h0;
      sync2_reg <= 4'h0;
    end
    else
    begin
      sync1_reg <= {chipLinkIn, tdmDataIn, frameSync, bitClk};
      sync2_reg <= sync1_reg;
    end
  end
  wire bclkS     = sync2_reg[0];
  wire fsS       = sync2_reg[1];
  wire bclkRise  = bclkS & ~bclkPrev_reg;
  wire bclkFall  = ~bclkS & bclkPrev_reg;
  wire frameEdge = bclkRise & fsS & ~fsPrev_reg;
  wire useLink   = (linkFn == LINK_FN_ALIGN);
  wire rxBit     = useLink ? sync2_reg[3] : sync2_reg[2];
  wire [4:0] curBit  = frameEdge ? 5'h00 : bitPos_reg;
  wire [5:0] curSlot = frameEdge ? 6'h00 : slotPos_reg;
  wire       slotEnd = bclkRise & (curBit == 5'(SLOT_BITS - 1));
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      bclkPrev_reg <= 1'b0;
      fsPrev_reg   <= 1'b0;
      bitPos_reg   <= 5'h00;
      slotPos_reg  <= 6'h3f;
    end
    else
    begin
      bclkPrev_reg <= bclkS;
      if (bclkRise)
      begin
        fsPrev_reg <= fsS;
        bitPos_reg <= slotEnd ? 5'h00 : curBit + 5'h01;
        if (slotEnd && curSlot != 6'h3f)
          slotPos_reg <= curSlot + 6'h01;
        else
          slotPos_reg <= curSlot;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Gain word transmit; bits change on the falling bit clock edge
  wire [23:0] txWord = bopAlignEn ? {limiterReduction[11:1], brownoutReduction}
                                  : {limiterReduction, 12'h000};
  wire        inTxSlot = txEnable & (slotPos_reg == txSlot) & (bitPos_reg < 5'(SLOT_BITS));
  wire        txBit    = txWord[5'(SLOT_BITS - 1) - bitPos_reg];
  logic       linkOe_reg, tdmOe_reg, txData_reg, keeper_reg;
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      linkOe_reg <= 1'b0;
      tdmOe_reg  <= 1'b0;
      txData_reg <= 1'b0;
      keeper_reg <= 1'b0;
    end
    else
    begin
      keeper_reg <= keeperEn;
      if (bclkFall)
      begin
        linkOe_reg <= inTxSlot & useLink;
        tdmOe_reg  <= inTxSlot & ~useLink;
        txData_reg <= inTxSlot & txBit;
      end
      else if (!txEnable)
      begin
        // Release at once rather than at the next bit edge
        linkOe_reg <= 1'b0;
        tdmOe_reg  <= 1'b0;
      end
    end
  end
  assign chipLinkOut    = txData_reg;
  assign chipLinkOe     = linkOe_reg;
  assign tdmDataOut     = txData_reg;
  assign tdmDataOe      = tdmOe_reg;
  assign chipLinkKeeper = keeper_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Gain word receive: largest reduction among listened slots wins
  logic [23:0] rxShift_reg;
  logic [11:0] rxLim_reg;
  logic [12:0] rxBop_reg;
  wire  [23:0] rxWord    = {rxShift_reg[22:0], rxBit};
  wire  [5:0]  groupIdx  = curSlot - firstSlot;
  wire         listened  = (groupIdx < 6'(GROUP_MAX)) && listenMask[groupIdx[2:0]];
  wire  [11:0] wordLim   = bopAlignEn ? {rxWord[23:13], 1'b0} : rxWord[23:12];
  wire  [12:0] wordBop   = bopAlignEn ? rxWord[12:0] : 13'h0000;
  wire  [11:0] limMax    = (wordLim > rxLim_reg) ? wordLim : rxLim_reg;
  wire  [12:0] bopMax    = (wordBop > rxBop_reg) ? wordBop : rxBop_reg;
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      rxShift_reg <= 24'h000000;
      rxLim_reg   <= 12'h000;
      rxBop_reg   <= 13'h0000;
    end
    else if (frameEdge)
    begin
      rxShift_reg <= {23'h000000, rxBit};
      rxLim_reg   <= 12'h000;
      rxBop_reg   <= 13'h0000;
    end
    else if (bclkRise)
    begin
      rxShift_reg <= rxWord;
      if (slotEnd && listened)
      begin
        rxLim_reg <= limMax;
        rxBop_reg <= bopMax;
      end
    end
  end
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      alignedLimiterReduction  <= 12'h000;
      alignedBrownoutReduction <= 13'h0000;
    end
    else
    begin
      alignedLimiterReduction  <= (limAlignEn && rxLim_reg > limiterReduction) ? rxLim_reg : limiterReduction;
      alignedBrownoutReduction <= (bopAlignEn && rxBop_reg > brownoutReduction) ? rxBop_reg
                                                                              : brownoutReduction;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sense DC block, one filter per channel; code zero bypasses
  logic signed [15:0] senseIn  [2];
  logic signed [15:0] senseOut [2];
  logic               sensePd  [2];
  assign senseIn[0] = currentSample;
  assign senseIn[1] = voltageSample;
  assign sensePd[0] = isnsPd;
  assign sensePd[1] = vsnsPd;
  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : dcBlock
      logic signed [23:0] acc_reg;
      wire  signed [23:0] err  = {senseIn[g], 8'h00} - acc_reg;
      wire  signed [15:0] hp   = senseIn[g] - acc_reg[23:8];
      always_ff @(posedge sys_clk or posedge reset)
      begin
        if (reset)
        begin
          acc_reg     <= 24'sh000000;
          senseOut[g] <= 16'sh0000;
        end
        else if (senseValid)
        begin
          acc_reg     <= (dcCutoff == 3'h0) ? 24'sh000000 : acc_reg + (err >>> dcCutoff);
          senseOut[g] <= sensePd[g] ? 16'sh0000 : (dcCutoff == 3'h0) ? senseIn[g] : hp;
        end
      end
    end
  endgenerate
  assign currentOut = senseOut[0];
  assign voltageOut = senseOut[1];

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_final_gain_min: assert property (@(posedge sys_clk) disable iff (reset)
    !$past(reset) |-> finalGain <= $past(supplyLimiterGain) && finalGain <= $past(brownoutGain))
    else $error("final gain above a limiter gain");
  a_bat_idle_high: assert property (@(posedge sys_clk) disable iff (reset)
    $past(batteryRes_reg) >= BAT_MV_3V2 |-> !batActive_reg)
    else $error("battery limiter active above threshold");
  a_bat_idle_low: assert property (@(posedge sys_clk) disable iff (reset)
    !$past(reset) && $past(progGain < 17'(batLimitGain)) |-> !batActive_reg
      && finalGain == (($past(supplyLimiterGain) < $past(brownoutGain)) ? $past(supplyLimiterGain)
                                                                        : $past(brownoutGain)))
    else $error("battery limiter active with low programmed gain");
  a_bat_limit_val: assert property (@(posedge sys_clk) disable iff (reset)
    batteryRes_reg < BAT_MV_2V8 |-> batLimitGain == BASE_LIMIT_GAIN + OFS_2V7)
    else $error("bottom battery limit gain wrong");
  a_tx_gated: assert property (@(posedge sys_clk) disable iff (reset)
    !txEnable ##1 !txEnable |-> !(chipLinkOe || tdmDataOe))
    else $error("slot driven while transmit disabled");
  a_one_pin: assert property (@(posedge sys_clk) disable iff (reset)
    !(chipLinkOe && tdmDataOe))
    else $error("both data pins driven");
  a_conv_spacing: assert property (@(posedge sys_clk) disable iff (reset)
    adcStart |=> !adcStart [*8])
    else $error("conversions too close");
  a_conv_busy: assert property (@(posedge sys_clk) disable iff (reset)
    adcStart |-> ##[1:60] convDone)
    else $error("conversion never finished");
  a_bat_conv_off: assert property (@(posedge sys_clk) disable iff (reset)
    adcStart && !$past(batConvEn) && !batConvEn |-> adcChannel != CH_BATTERY)
    else $error("battery converted while disabled");
  a_sense_null: assert property (@(posedge sys_clk) disable iff (reset)
    $past(senseValid) && $past(isnsPd) |-> currentOut == 16'sh0000)
    else $error("powered-down current sense not null");
  a_align_off: assert property (@(posedge sys_clk) disable iff (reset)
    !$past(limAlignEn) |-> alignedLimiterReduction == $past(limiterReduction))
    else $error("limiter aligned while disabled");
  c_tx_slot:   cover property (@(posedge sys_clk) disable iff (reset) $rose(chipLinkOe));
  c_tdm_tx:    cover property (@(posedge sys_clk) disable iff (reset) $rose(tdmDataOe));
  c_bat_limit: cover property (@(posedge sys_clk) disable iff (reset) $rose(batActive_reg));
  c_rx_align:  cover property (@(posedge sys_clk) disable iff (reset) slotEnd && listened && limAlignEn);
endmodule : gain_limit_alignment

// ===== sim/peer_amp_model.sv
// Peer amplifier that sends its reduction word in one slot of the shared line
`timescale 1ns/10ps
module peer_amp_model
#(
  parameter int FRAME_BITS = 96
)
(
  // Link timing
  input  wire logic        bitClk,
  input  wire logic        frameSync,
  // Slot content
  input  wire logic [5:0]  slot,
  input  wire logic [23:0] word,
  // Shared data line
  output logic             dataLine
);
  int   bitCnt = 0;
  int   nxt;
  logic lastFs = 1'b0;
  initial dataLine = 1'b0;
  always @(posedge bitClk)
  begin
    bitCnt = (frameSync && !lastFs) ? 0 : bitCnt + 1;
    lastFs = frameSync;
  end
  // Outside its slot the line toggles, so a listener on a wrong slot sees garbage
  always @(negedge bitClk)
  begin
    nxt = (bitCnt + 1) % FRAME_BITS;
    dataLine = (nxt / 24 == int'(slot)) ? word[23 - nxt % 24] : ~dataLine;
  end
endmodule : peer_amp_model

// ===== sim/tb_gain_limit_alignment.sv
// Self-checking bench for the protection-gain block
`timescale 1ns/10ps
module tb_gain_limit_alignment;
  import gain_align_pkg::*;
  logic               sys_clk, reset, bitClk, frameSync, peerLine, senseValid, err;
  logic               tdmDataOut, tdmDataOe, chipLinkOut, chipLinkOe, chipLinkKeeper, adcStart;
  apb_req_t           apbReq;
  apb_rsp_t           apbRsp;
  adc_chan_t          adcChannel;
  logic signed [15:0] supGain, bopGain, finalGain, curIn, volIn, currentOut, voltageOut;
  logic [11:0]        limRed, alignedLim, adcResult;
  logic [12:0]        bopRed, alignedBop;
  logic [5:0]         peerSlot;
  logic [23:0]        peerWord, w;
  logic [15:0]        seed;
  logic [31:0]        q;
  int                 n_fail, check_count, fb, i, n;
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  // Link clock runs free with an offset so its edges never meet sys_clk edges
  initial
  begin
    bitClk = 1'b0;
    #130;
    forever #400 bitClk = ~bitClk;
  end
  always @(negedge bitClk)
  begin
    fb = (fb + 1) % 96;
    frameSync = (fb == 0);
  end
  initial
  begin
    #10ms;
    n_fail++;
    test_done();
  end
  gain_limit_alignment dut_u (.sys_clk(sys_clk), .reset(reset), .apbReq(apbReq), .apbRsp(apbRsp),
    .bitClk(bitClk), .frameSync(frameSync), .tdmDataIn(peerLine), .tdmDataOut(tdmDataOut),
    .tdmDataOe(tdmDataOe), .chipLinkIn(peerLine), .chipLinkOut(chipLinkOut), .chipLinkOe(chipLinkOe),
    .chipLinkKeeper(chipLinkKeeper), .supplyLimiterGain(supGain), .brownoutGain(bopGain),
    .limiterReduction(limRed), .brownoutReduction(bopRed), .finalGain(finalGain),
    .alignedLimiterReduction(alignedLim), .alignedBrownoutReduction(alignedBop), .adcStart(adcStart),
    .adcChannel(adcChannel), .adcResult(adcResult), .currentSample(curIn), .voltageSample(volIn),
    .senseValid(senseValid), .currentOut(currentOut), .voltageOut(voltageOut));
  peer_amp_model peer_u (.bitClk(bitClk), .frameSync(frameSync), .slot(peerSlot), .word(peerWord),
    .dataLine(peerLine));
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] rnd();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return seed;
  endfunction : rnd
  function automatic logic signed [15:0] exp_gain(input int k, input logic on);
    logic signed [15:0] ofs[6] = '{OFS_3V2, OFS_3V1, OFS_3V0, OFS_2V9, OFS_2V8, OFS_2V7};
    logic signed [15:0] g;
    g = (supGain < bopGain) ? supGain : bopGain;
    if (on && k > 0 && BASE_LIMIT_GAIN + ofs[k] < g)
      g = BASE_LIMIT_GAIN + ofs[k];
    return g;
  endfunction : exp_gain
  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    check_count++;
    if (got !== want)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t got %h want %h", $time, got, want);
    end
  endtask : chk
  task automatic test_done();
    $display("checks %0d failures %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : test_done
  // Slave answer time is not assumed; pready and read data are taken at the same rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int t;
    @(posedge sys_clk);
    apbReq <= '{1'b1, 1'b0, wr, a, d};
    @(posedge sys_clk);
    apbReq.penable <= 1'b1;
    for (t = 0; t < 20; t++)
    begin
      @(posedge sys_clk);
      if (apbRsp.pready === 1'b1)
        break;
    end
    if (t == 20)
    begin
      n_fail++;
      test_done();
    end
    q = apbRsp.prdata;
    err = apbRsp.pslverr;
    apbReq <= '0;
  endtask : apb
  task automatic grab(input logic lnk);
    int t;
    n = 0;
    for (t = 0; t < 400 && n < 25; t++)
    begin
      @(posedge bitClk);
      if ((lnk ? chipLinkOe : tdmDataOe) === 1'b1)
      begin
        w = {w[22:0], lnk ? chipLinkOut : tdmDataOut};
        n++;
      end
      else if (n > 0)
        break;
    end
  endtask : grab
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    seed = 16'h0030;
    {n_fail, check_count, fb} = '0;
    {reset, frameSync, senseValid} = 3'b100;
    {supGain, bopGain, curIn, volIn, peerWord, limRed, bopRed, adcResult, peerSlot} = '0;
    apbReq = '0;
    repeat (12) @(posedge sys_clk);
    reset <= 1'b0;
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk(q, {24'h0, CTRL_RESET});
    apb(1'b0, 8'h1c, 32'h0);
    chk({err, q}, {1'b1, 32'h0});
    for (i = 0; i < 12; i++)
    begin
      apb(1'b1, ADDR_GAINS, (i < 6) ? 32'h03e8_05dc : 32'h0);
      adcResult <= 12'(3200 - 100 * (i % 6)) + 12'(rnd() % 100);
      supGain <= 16'sd1700 + 16'(rnd() % 700);
      bopGain <= 16'sd1700 + 16'(rnd() % 700);
      repeat (300) @(posedge sys_clk);
      chk(finalGain, exp_gain(i % 6, i < 6));
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk(q[16], i < 6 && i % 6 > 0);
      apb(1'b0, ADDR_RESV, 32'h0);
      chk(q & 32'h0fff_0fff, {4'h0, adcResult, 4'h0, adcResult});
    end
    for (i = 0; i < 4; i++)
    begin
      limRed <= 12'(rnd());
      bopRed <= 13'(rnd());
      apb(1'b1, ADDR_CTRL, {24'h0, i == 2, 4'h1, i == 1 || i == 2, 1'b0, i < 3});
      apb(1'b1, ADDR_SLOTS, {5'h0, (i == 2) ? LINK_FN_ALIGN : 3'h0, 24'h01});
      @(posedge frameSync);
      grab(i == 2);
      chk(n, i < 3 ? 24 : 0);
      chk(chipLinkKeeper, i == 2);
      if (i < 3)
        chk(w, (i == 0) ? {limRed, 12'h0} : {limRed[11:1], bopRed});
    end
    apb(1'b1, ADDR_SLOTS, 32'h0002_0101);
    peerSlot <= 6'd2;
    for (i = 0; i < 2; i++)
    begin
      limRed <= 12'(rnd()) & 12'h7ff;
      peerWord <= {12'h800 | 12'(rnd()), 12'h0};
      apb(1'b1, ADDR_CTRL, {28'h1, 1'b0, 1'b0, i == 0, 1'b0});
      @(posedge frameSync);
      repeat (80) @(posedge bitClk);
      chk(alignedLim == peerWord[23:12], i == 0);
    end
    for (i = 0; i < 2; i++)
    begin
      apb(1'b1, ADDR_CTRL, {26'h0, i == 1, i == 0, 4'h8});
      curIn <= rnd() & 16'h7fff | 16'h1;
      volIn <= rnd() & 16'h7fff | 16'h1;
      senseValid <= 1'b1;
      @(posedge sys_clk);
      senseValid <= 1'b0;
      repeat (4) @(posedge sys_clk);
      chk(currentOut, (i == 0) ? 16'sh0 : curIn);
      chk(voltageOut, (i == 1) ? 16'sh0 : volIn);
    end
    // Filter on: a constant input must settle near zero
    apb(1'b1, ADDR_CTRL, 32'h08);
    apb(1'b1, ADDR_SLOTS, 32'h1000_0000);
    for (i = 0; i < 30; i++)
    begin
      senseValid <= 1'b1;
      @(posedge sys_clk);
    end
    senseValid <= 1'b0;
    repeat (2) @(posedge sys_clk);
    chk(voltageOut >= 16'sd0 && voltageOut <= 16'sd2, 1'b1);
    test_done();
  end
endmodule : tb_gain_limit_alignment
